// ### logic/link_pkg.sv
// Shared constants for the parallel-to-serial bus extender.
// Assumes one system clock samples both the bus clock pin and the link lanes.
package link_pkg;
  // Serial slots that each data lane carries per bus clock period
  localparam int unsigned BITS_PER_LANE  = 7;
  // Data lanes of the narrow (21-bit) and wide (28-bit) variants
  localparam int unsigned LANES_NARROW   = 3;
  localparam int unsigned LANES_WIDE     = 4;
  // Slots of a frame during which the forwarded clock lane is high
  localparam int unsigned CLK_HIGH_SLOTS = 4;
  // Width of the slot counter, enough for BITS_PER_LANE slots
  localparam int unsigned SLOT_W         = 3;
  // Last slot index of a frame, at counter width
  localparam logic [2:0]  LAST_SLOT      = 3'h6;
  // Slot index after which the forwarded clock lane drops
  localparam logic [2:0]  CLK_LOW_SLOT   = 3'h3;
  // Cycles for which the recovered clock stays high after a word
  localparam logic [2:0]  RCLK_HIGH      = 3'h4;
endpackage : link_pkg

// ### logic/lane_serializer.sv
// One serial data lane: loads a seven-bit slice and sends it high bit first.
// Assumes the controller issues load in slot 0 and shift in slots 1 to 6.
module lane_serializer (
  input  wire logic       i_sys_clk,
  input  wire logic       i_srst,
  input  wire logic       i_clk_en,
  input  wire logic       i_load,
  input  wire logic       i_shift,
  input  wire logic [6:0] i_slice,
  output logic            o_bit
);
  logic [6:0] shreg;

  // Output bit is a flop; idle lane drops to zero when neither load nor shift
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      shreg <= 7'h00;
      o_bit <= 1'b0;
    end else if (i_clk_en) begin
      if (i_load) begin
        o_bit <= i_slice[6];
        shreg <= {i_slice[5:0], 1'b0};
      end else if (i_shift) begin
        o_bit <= shreg[6];
        shreg <= {shreg[5:0], 1'b0};
      end else begin
        o_bit <= 1'b0;
      end
    end
  end
endmodule // lane_serializer

// ### logic/serial_link.sv
// Bus extender core: transmitter that serialises the parallel word, and
// receiver that rebuilds it from the lanes and a forwarded clock lane.
// Assumes the bus clock and the received lanes are asynchronous pins, the
// bus clock period spans at least seven system clocks, and the far sender
// emits one slot per system clock at the same rate as this clock.
//
// Overview of operation
// - Narrow variant: 21-bit word over three data lanes plus a clock lane.
// - Wide variant: 28-bit word over four data lanes plus a clock lane.
// - Bus clock arrives on its own input and is aligned before serialising.
// - Parallel bits go onto the data lanes; clock drives a separate lane.
// - Receiver rebuilds the word from lanes and presents it with a clock.
// - Narrow word suits two bytes, two parity bits and three control bits.
// - Wide word suits three bytes, three parity bits and one control bit.
// - Power-down stops all activity and parks outputs at zero.
// - Word is captured at the rising bus clock edge; inputs settle earlier.
module serial_link #(
  parameter int unsigned LANES = link_pkg::LANES_NARROW,
  parameter int unsigned WORD  = LANES * link_pkg::BITS_PER_LANE
) (
  input  wire logic            i_sys_clk,
  input  wire logic            i_srst,
  input  wire logic            i_clk_en,
  input  wire logic            i_power_down,
  input  wire logic            i_tx_clock_in,
  input  wire logic [WORD-1:0] i_tx_parallel_in,
  output logic [LANES-1:0]     o_tx_lane,
  output logic                 o_tx_clk_lane,
  input  wire logic [LANES-1:0] i_rx_lane,
  input  wire logic            i_rx_clk_lane,
  output logic [WORD-1:0]      o_rx_parallel_out,
  output logic                 o_rx_clock_out,
  output logic                 o_rx_word_valid
);
  localparam int unsigned BPL = link_pkg::BITS_PER_LANE;

  // Transmit side state
  logic [2:0]      txclk_sync;
  logic [WORD-1:0] txd_s1;
  logic [WORD-1:0] txd_s2;
  logic [WORD-1:0] txd_s3;
  logic [2:0]      tx_slot;
  logic            tx_active;
  logic            lane_clk;

  // Receive side state
  logic [LANES-1:0]       rxl_s1;
  logic [LANES-1:0]       rxl_s2;
  logic [2:0]             rxclk_sync;
  logic [LANES*(BPL-1)-1:0] rx_shreg;
  logic [2:0]             rx_slot;
  logic                   rx_active;
  logic [2:0]             rclk_cnt;
  logic [WORD-1:0]        rx_word;
  logic                   rx_clk_out;
  logic                   rx_valid;

  // Edge detect reads only the second and third stages of each synchroniser
  wire tx_rise   = txclk_sync[1] & ~txclk_sync[2];
  wire rx_rise   = rxclk_sync[1] & ~rxclk_sync[2];
  wire run       = i_clk_en & ~i_power_down;
  wire tx_load   = run & tx_rise;
  wire tx_shift  = run & tx_active & ~tx_rise;
  wire tx_last   = tx_slot == link_pkg::LAST_SLOT;
  wire rx_last   = rx_active & (rx_slot == link_pkg::LAST_SLOT);

  // Power-down gating
  // Stopping the clock enable of the synchroniser flops and clearing the rest except the shift registers keeps the design quiet
  // without gating the clock itself.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      txclk_sync <= 3'h0;
      rxclk_sync <= 3'h0;
      txd_s1     <= '0;
      txd_s2     <= '0;
      txd_s3     <= '0;
      rxl_s1     <= '0;
      rxl_s2     <= '0;
    end else if (run) begin
      txclk_sync <= {txclk_sync[1:0], i_tx_clock_in};
      rxclk_sync <= {rxclk_sync[1:0], i_rx_clk_lane};
      txd_s1     <= i_tx_parallel_in;
      txd_s2     <= txd_s1;
      txd_s3     <= txd_s2;
      rxl_s1     <= i_rx_lane;
      rxl_s2     <= rxl_s1;
    end
  end

  // Capture at rising edge
  // The third data stage lines up with the clock sample taken just before
  // the edge, so the word latched is the one settled ahead of that edge.
  // Lane slicing
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_tx_lane
      lane_serializer u_ser (
        .i_sys_clk (i_sys_clk),
        .i_srst    (i_srst),
        .i_clk_en  (i_clk_en),
        .i_load    (tx_load),
        .i_shift   (tx_shift),
        .i_slice   (txd_s3[g*BPL +: BPL]),
        .o_bit     (o_tx_lane[g])
      );
    end
  endgenerate

  // Slot counter
  // A new edge restarts the frame; bus clocks faster than seven system
  // clocks would cut frames short, which is a limit of this sampling scheme.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      tx_slot   <= 3'h0;
      tx_active <= 1'b0;
    end else if (i_clk_en) begin
      if (i_power_down) begin
        tx_slot   <= 3'h0;
        tx_active <= 1'b0;
      end else if (tx_load) begin
        tx_slot   <= 3'h1;
        tx_active <= 1'b1;
      end else if (tx_shift) begin
        tx_slot   <= tx_last ? 3'h0 : tx_slot + 3'h1;
        tx_active <= ~tx_last;
      end
    end
  end

  // Forwarded clock lane
  // High for the first four slots of a frame, low for the last three.
  wire next_lane_clk = tx_load | (tx_shift & (tx_slot <= link_pkg::CLK_LOW_SLOT));

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      lane_clk <= 1'b0;
    end else if (i_clk_en) begin
      lane_clk <= next_lane_clk;
    end
  end

  assign o_tx_clk_lane = lane_clk;

  // Same mapping both ends
  // Received slot order matches the sent order, high bit first.
  logic [WORD-1:0] next_word;
  generate
    for (g = 0; g < LANES; g++) begin : g_rx_lane
      assign next_word[g*BPL +: BPL] = {rx_shreg[g*(BPL-1) +: BPL-1], rxl_s2[g]};
    end
  endgenerate

  // Receive shifter; the clock lane's rising edge marks slot 0
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      rx_shreg  <= '0;
      rx_slot   <= 3'h0;
      rx_active <= 1'b0;
    end else if (i_clk_en) begin
      if (i_power_down) begin
        rx_slot   <= 3'h0;
        rx_active <= 1'b0;
      end else if (rx_rise) begin
        for (int l = 0; l < LANES; l++) begin
          rx_shreg[l*(BPL-1) +: BPL-1] <= {{(BPL-2){1'b0}}, rxl_s2[l]};
        end
        rx_slot   <= 3'h1;
        rx_active <= 1'b1;
      end else if (rx_active) begin
        for (int l = 0; l < LANES; l++) begin
          rx_shreg[l*(BPL-1) +: BPL-1] <= next_word[l*BPL +: BPL-1];
        end
        rx_slot   <= rx_last ? 3'h0 : rx_slot + 3'h1;
        rx_active <= ~rx_last;
      end
    end
  end

  // Recovered clock
  // Word and clock rise together; the word holds until the next frame ends.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      rx_word    <= '0;
      rx_valid   <= 1'b0;
      rx_clk_out <= 1'b0;
      rclk_cnt   <= 3'h0;
    end else if (i_clk_en) begin
      if (i_power_down) begin
        rx_word    <= '0;
        rx_valid   <= 1'b0;
        rx_clk_out <= 1'b0;
        rclk_cnt   <= 3'h0;
      end else if (rx_last & ~rx_rise) begin
        rx_word    <= next_word;
        rx_valid   <= 1'b1;
        rx_clk_out <= 1'b1;
        rclk_cnt   <= link_pkg::RCLK_HIGH - 3'h1;
      end else begin
        rx_valid   <= 1'b0;
        rx_clk_out <= rclk_cnt != 3'h0;
        rclk_cnt   <= (rclk_cnt != 3'h0) ? rclk_cnt - 3'h1 : 3'h0;
      end
    end
  end

  // Field use is left to the bus side; the word passes untouched
  assign o_rx_parallel_out = rx_word;
  assign o_rx_clock_out    = rx_clk_out;
  assign o_rx_word_valid   = rx_valid;
endmodule // serial_link

// ### verification/link_sva.sv
// Checker for the bus extender core: frame shape, latency and output timing.
// Assumes it sees only the core's ports and is bound to every instance.
module link_sva #(
  parameter int unsigned LANES = 3,
  parameter int unsigned WORD  = 21
) (
  input wire logic             i_sys_clk,
  input wire logic             i_srst,
  input wire logic             i_power_down,
  input wire logic             i_tx_clock_in,
  input wire logic [LANES-1:0] o_tx_lane,
  input wire logic             o_tx_clk_lane,
  input wire logic             i_rx_clk_lane,
  input wire logic [WORD-1:0]  o_rx_parallel_out,
  input wire logic             o_rx_clock_out,
  input wire logic             o_rx_word_valid
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);
  // Forwarded clock lane: slots 0-3 high, then slots 4-6 low
  sequence tx_high_s; $rose(o_tx_clk_lane) ##1 o_tx_clk_lane [*3]; endsequence
  sequence tx_low_s; !o_tx_clk_lane [*3]; endsequence
  chk_clk_lane_duty: assert property (tx_high_s |=> tx_low_s)
    else $error("clock lane duty wrong");
  chk_idle_lanes_zero: assert property (tx_high_s ##1 tx_low_s ##1 !o_tx_clk_lane |->
    o_tx_lane == '0) else $error("data lanes not idle");
  chk_bus_edge_frame: assert property ($rose(i_tx_clock_in) && !i_power_down |->
    ##[2:6] $rose(o_tx_clk_lane)) else $error("no frame after bus edge");
  // Power-down with the clock enable high parks the data lanes, clock lane, recovered clock and valid one cycle later, whatever was running
  chk_power_down_quiet: assert property (i_power_down |=> o_tx_lane == '0 &&
    !o_tx_clk_lane && !o_rx_clock_out && !o_rx_word_valid) else $error("active in power down");
  chk_rx_latency: assert property ($rose(i_rx_clk_lane) && !i_power_down |->
    ##[8:11] o_rx_word_valid) else $error("rebuilt word late");
  chk_valid_pulse: assert property (o_rx_word_valid |=> !o_rx_word_valid)
    else $error("valid longer than one cycle");
  chk_valid_clock: assert property (o_rx_word_valid |-> $rose(o_rx_clock_out))
    else $error("valid without clock rise");
  chk_rclk_width: assert property ($rose(o_rx_clock_out) |->
    o_rx_clock_out [*4] ##1 !o_rx_clock_out) else $error("recovered clock width wrong");
  // Output word may only move with valid or after power-down cleared it
  chk_word_held: assert property (!o_rx_word_valid && !$past(i_power_down) |->
    $stable(o_rx_parallel_out)) else $error("word changed without valid");
endmodule // link_sva

bind serial_link link_sva #(.LANES(LANES), .WORD(WORD)) u_link_sva (
  .i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_power_down(i_power_down),
  .i_tx_clock_in(i_tx_clock_in), .o_tx_lane(o_tx_lane), .o_tx_clk_lane(o_tx_clk_lane),
  .i_rx_clk_lane(i_rx_clk_lane), .o_rx_parallel_out(o_rx_parallel_out),
  .o_rx_clock_out(o_rx_clock_out), .o_rx_word_valid(o_rx_word_valid));

// ### verification/far_sender.sv
// Far-end sender model: serialises words onto the receive lanes.
// Assumes one slot per system clock; start held high gives back-to-back frames.
module far_sender #(
  parameter int unsigned LANES = 3
) (
  input  wire logic               i_sys_clk,
  input  wire logic               i_start,
  input  wire logic [LANES*7-1:0] i_word,
  output logic [LANES-1:0]        o_lane = '0,
  output logic                    o_clk_lane = 1'b0
);
  timeunit 1ns;
  timeprecision 100ps;
  int                 slot = 7;
  logic [LANES*7-1:0] word;
  // Seven slots high bit first, same mapping as the core
  always @(posedge i_sys_clk) begin
    if (slot == 7 && i_start) begin
      word = i_word;
      slot = 0;
    end
    if (slot < 7) begin
      for (int l = 0; l < LANES; l++) o_lane[l] <= word[7*l+6-slot];
      o_clk_lane <= (slot < 4);
      slot = slot + 1;
    end else begin
      o_lane     <= ~o_lane; // Released lanes toggle so stale data never looks valid
      o_clk_lane <= 1'b0;    // Clock lane stands still between frames
    end
  end
endmodule // far_sender

// ### verification/tb.sv
// Self-checking bench for the narrow bus extender core.
// Assumes far_sender drives the receive lanes; transmit lanes are decoded here.
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned LANES = link_pkg::LANES_NARROW;
  localparam int unsigned WORD  = LANES * link_pkg::BITS_PER_LANE;
  logic i_sys_clk = 0, i_srst = 1, i_clk_en = 1, i_power_down = 0, i_tx_clock_in = 0, start = 0;
  logic [WORD-1:0]  i_tx_parallel_in = '0, far_word = '0, o_rx_parallel_out, got;
  logic [LANES-1:0] o_tx_lane, i_rx_lane;
  logic             o_tx_clk_lane, i_rx_clk_lane, o_rx_clock_out, o_rx_word_valid;
  int               n_errors = 0, total_checks = 0, cycles = 0;
  serial_link #(.LANES(LANES)) DUT (.i_sys_clk(i_sys_clk), .i_srst(i_srst),
    .i_clk_en(i_clk_en), .i_power_down(i_power_down), .i_tx_clock_in(i_tx_clock_in),
    .i_tx_parallel_in(i_tx_parallel_in), .o_tx_lane(o_tx_lane), .o_tx_clk_lane(o_tx_clk_lane),
    .i_rx_lane(i_rx_lane), .i_rx_clk_lane(i_rx_clk_lane), .o_rx_parallel_out(o_rx_parallel_out),
    .o_rx_clock_out(o_rx_clock_out), .o_rx_word_valid(o_rx_word_valid));
  far_sender #(.LANES(LANES)) u_far (.i_sys_clk(i_sys_clk), .i_start(start), .i_word(far_word),
    .o_lane(i_rx_lane), .o_clk_lane(i_rx_clk_lane));
  always #12.5 i_sys_clk = ~i_sys_clk;
  // A hang counts as a mismatch
  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  task automatic check(string name, logic [WORD-1:0] seen, logic [WORD-1:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Two bytes with even parity, the second made odd when flip is set, plus three control bits
  function automatic logic [WORD-1:0] par_word(logic [7:0] b0, logic [7:0] b1, logic [2:0] c,
                                                logic flip);
    return {c, ^b1 ^ flip, b1, ^b0, b0};
  endfunction
  // One bus clock period of 200 ns; lanes decoded slot by slot
  task automatic tx_frame(logic [WORD-1:0] w);
    int n;
    fork
      begin
        @(posedge i_sys_clk) i_tx_parallel_in <= w;
        repeat (4) @(posedge i_sys_clk);
        i_tx_clock_in <= 1'b1;
        repeat (4) @(posedge i_sys_clk);
        i_tx_clock_in <= 1'b0;
      end
      begin
        n = 0;
        do begin
          @(negedge i_sys_clk);
          n++;
        end while (o_tx_clk_lane !== 1'b1 && n < 30);
        for (int s = 0; s < 7; s++) begin
          for (int l = 0; l < LANES; l++) got[7*l+6-s] = o_tx_lane[l];
          @(negedge i_sys_clk);
        end
      end
    join
    check("tx lanes", got, w);
  endtask
  // Two receive frames back to back; the second carries a parity fault
  task automatic rx_pair(logic [WORD-1:0] a, logic [WORD-1:0] b);
    logic [WORD-1:0] exp [2];
    int n;
    exp = '{a, b};
    @(posedge i_sys_clk) begin far_word <= a; start <= 1'b1; end
    @(posedge i_sys_clk) far_word <= b;
    repeat (7) @(posedge i_sys_clk);
    start <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      n = 0;
      do begin
        @(negedge i_sys_clk);
        n++;
      end while (o_rx_word_valid !== 1'b1 && n < 30);
      check("rx word", o_rx_parallel_out, exp[k]);
      check("rx clock", WORD'(o_rx_clock_out), WORD'(1));
      if (k == 1) check("word spacing", WORD'(n), WORD'(link_pkg::BITS_PER_LANE));
      check("parity error", WORD'((^o_rx_parallel_out[8:0]) | (^o_rx_parallel_out[17:9])),
            WORD'(k));
    end
  endtask
  // Power-down while idle clears the held word; a low clock enable defers it
  task automatic power_down_test(logic [WORD-1:0] held);
    repeat (4) @(posedge i_sys_clk);
    i_clk_en     <= 1'b0;
    i_power_down <= 1'b1;
    repeat (3) @(negedge i_sys_clk);
    check("rx word while frozen", o_rx_parallel_out, held);
    @(posedge i_sys_clk) i_clk_en <= 1'b1;
    repeat (2) @(negedge i_sys_clk);
    check("rx word in power down", o_rx_parallel_out, '0);
    @(posedge i_sys_clk) i_power_down <= 1'b0;
  endtask
  initial begin
    repeat (6) @(posedge i_sys_clk);
    i_srst <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
    tx_frame(par_word(8'ha5, 8'h3c, 3'h5, 1'b0));
    tx_frame(par_word(8'hff, 8'h01, 3'h2, 1'b0));
    tx_frame({WORD{1'b1}});
    rx_pair(par_word(8'h81, 8'h7e, 3'h7, 1'b0), par_word(8'h00, 8'hc3, 3'h1, 1'b1));
    power_down_test(par_word(8'h00, 8'hc3, 3'h1, 1'b1));
    tx_frame(par_word(8'h5a, 8'h96, 3'h3, 1'b0));
    tally_and_finish();
  end
endmodule // tb
